// file: hw/sec_core.sv
// Serial engine common core: registers, rate select, address match, flags
//
// The register addresses and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Three-bit mode field selects function
// - Enable bit activates, clearing deactivates
// - Soft reset restores registers except debug
// - Rate reference is internal or external clock
// - Async: transmit /16, receive /1
// - Sync: both directions use /2
// - Divider output chosen by mode automatically; the code uses the sync_comm bit in the two USART modes
// - Divisor 16 bits async, 8 sync
// - Async rate ref/16 times (1-B/65536)
// - Sync rate ref over 2(B+1)
// - Address match uses seven or eight bits
// - Masked bits ignored; ones accept all
// - Dual match: address or mask value
// - Range match between mask and address
// - Flags set on events; enabled raise request
// - Unmask set and clear registers
// - Request holds until flag, enable, reset
// - One shared request; flags show cause
// - Crossing busy set at once, ready flags
// - Access while busy stalls, then completes; the code stalls only writes to control and rate, and reads never stall
// - Runs in low power while clocked
module sec_core
    import sec_pkg::*;
#(
    parameter int N_ENG_EV = ENG_EV_N
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [7:0] s_awaddr,
    input wire logic s_wvalid,
    output logic s_wready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    output logic s_bvalid,
    input wire logic s_bready,
    output logic [1:0] s_bresp,
    // AXI4-Lite read
    input wire logic s_arvalid,
    output logic s_arready,
    input wire logic [7:0] s_araddr,
    output logic s_rvalid,
    input wire logic s_rready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    // Engine side
    input wire logic ext_clk_pin,
    input wire logic [N_ENG_EV-1:0] eng_events,
    input wire logic match_valid,
    input wire logic [7:0] match_addr,
    output logic match_hit,
    output logic eng_active,
    output logic [2:0] eng_mode,
    output logic dbg_halt_en,
    output logic tx_tick,
    output logic rx_tick,
    // Combined request
    output logic irq
);
    localparam int NF = N_ENG_EV + 2;

    sec_ctrl_s ctrl_q;
    sec_ctrl_s eng_ctrl_q;
    sec_match_s match_q;
    logic [RATE_W-1:0] rate_q;
    logic [RATE_W-1:0] eng_rate_q;
    logic dbg_q;
    logic [NF-1:0] ien_q;
    logic [NF-1:0] flag_q;
    logic busy_q;
    logic [2:0] sync_cnt_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic ext_s1_q;
    logic ext_s2_q;
    logic ext_s3_q;
    logic hit_q;

    // Write address decode
    logic [7:0] aw_off_w;
    logic aw_ctrl_w, aw_dbg_w, aw_rate_w, aw_iec_w, aw_ies_w;
    logic aw_flag_w, aw_match_w, aw_map_w, aw_sync_w;
    assign aw_off_w = {s_awaddr[7:2], 2'b00};
    assign aw_ctrl_w = aw_off_w == OFS_CTRL;
    assign aw_dbg_w = aw_off_w == OFS_DBG;
    assign aw_rate_w = aw_off_w == OFS_RATE;
    assign aw_iec_w = aw_off_w == OFS_IEC;
    assign aw_ies_w = aw_off_w == OFS_IES;
    assign aw_flag_w = aw_off_w == OFS_FLAG;
    assign aw_match_w = aw_off_w == OFS_MATCH;
    // Map has no holes
    assign aw_map_w = aw_off_w <= OFS_MATCH;
    // Control and divisor live on the engine side and need a crossing
    assign aw_sync_w = aw_ctrl_w | aw_rate_w;

    // Write handshake: both channels taken in the same cycle
    logic wr_stall_w, wr_fire_w, sync_wr_w;
    assign wr_stall_w = busy_q & aw_sync_w;
    assign s_awready = s_wvalid & ~bvalid_q & ~wr_stall_w;
    assign s_wready = s_awvalid & ~bvalid_q & ~wr_stall_w;
    assign wr_fire_w = s_awvalid & s_wvalid & ~bvalid_q & ~wr_stall_w;
    assign sync_wr_w = wr_fire_w & aw_sync_w;

    // Byte lane merge
    logic [31:0] wmask_w, wbits_w, ctrl_mrg_w, rate_mrg_w, match_mrg_w;
    sec_ctrl_s ctrl_new_w;
    sec_match_s match_new_w;
    assign wmask_w = {{8{s_wstrb[3]}}, {8{s_wstrb[2]}}, {8{s_wstrb[1]}}, {8{s_wstrb[0]}}};
    assign wbits_w = s_wdata & wmask_w;
    assign ctrl_mrg_w = ({26'h0, ctrl_q} & ~wmask_w) | wbits_w;
    assign rate_mrg_w = ({16'h0, rate_q} & ~wmask_w) | wbits_w;
    assign match_mrg_w = ({6'h0, match_q} & ~wmask_w) | wbits_w;
    assign ctrl_new_w = ctrl_mrg_w[CTRL_W-1:0];
    assign match_new_w = {match_mrg_w[25:16], 8'h00, match_mrg_w[7:0]};

    logic srst_req_w, sync_done_w;
    assign srst_req_w = wr_fire_w & aw_ctrl_w & ctrl_new_w.soft_reset_bit;
    assign sync_done_w = busy_q & (sync_cnt_q == 3'h1);

    // Interrupt enable and flag updates
    logic [NF-1:0] ien_set_w, ien_clr_w, flag_clr_w, flag_set_w;
    assign ien_set_w = (wr_fire_w & aw_ies_w) ? wbits_w[NF-1:0] : '0;
    assign ien_clr_w = (wr_fire_w & aw_iec_w) ? wbits_w[NF-1:0] : '0;
    assign flag_clr_w = (wr_fire_w & aw_flag_w) ? wbits_w[NF-1:0] : '0;
    // Engine sources count only while a valid mode runs
    assign flag_set_w = {eng_events & {N_ENG_EV{eng_active}}, hit_q, sync_done_w};

    // Bus side registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= CTRL_RST;
            rate_q <= RATE_RST;
            match_q <= MATCH_RST;
            dbg_q <= 1'b0;
            ien_q <= '0;
            flag_q <= '0;
        end else if (srst_req_w) begin
            ctrl_q <= CTRL_SRST_VAL;
            rate_q <= RATE_RST;
            match_q <= MATCH_RST;
            ien_q <= '0;
            flag_q <= '0;
        end else begin
            if (wr_fire_w && aw_ctrl_w) begin
                ctrl_q <= ctrl_new_w;
            end else if (sync_done_w) begin
                ctrl_q.soft_reset_bit <= 1'b0;
            end
            if (wr_fire_w && aw_rate_w) begin
                rate_q <= rate_mrg_w[RATE_W-1:0];
            end
            if (wr_fire_w && aw_match_w) begin
                match_q <= match_new_w;
            end
            if (wr_fire_w && aw_dbg_w) begin
                dbg_q <= wbits_w[0];
            end
            ien_q <= (ien_q | ien_set_w) & ~ien_clr_w;
            // Set wins over a clear in the same cycle
            flag_q <= (flag_q & ~flag_clr_w) | flag_set_w;
        end
    end

    // Crossing sequencer: engine copies update when busy ends
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            busy_q <= 1'b0;
            sync_cnt_q <= 3'h0;
            eng_ctrl_q <= CTRL_RST;
            eng_rate_q <= RATE_RST;
        end else if (sync_wr_w) begin
            busy_q <= 1'b1;
            sync_cnt_q <= SYNC_CNT_INIT;
        end else if (busy_q) begin
            sync_cnt_q <= sync_cnt_q - 3'h1;
            if (sync_done_w) begin
                busy_q <= 1'b0;
                eng_ctrl_q <= ctrl_q;
                eng_ctrl_q.soft_reset_bit <= 1'b0;
                eng_rate_q <= rate_q;
            end
        end
    end

    // Write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (wr_fire_w) begin
            bvalid_q <= 1'b1;
            bresp_q <= aw_map_w ? RESP_OKAY : RESP_SLVERR;
        end else if (s_bready) begin
            bvalid_q <= 1'b0;
        end
    end
    assign s_bvalid = bvalid_q;
    assign s_bresp = bresp_q;

    // Read path
    logic [7:0] ar_off_w;
    logic ar_fire_w, ar_map_w;
    logic [31:0] rd_val_w;
    assign ar_off_w = {s_araddr[7:2], 2'b00};
    assign s_arready = ~rvalid_q;
    assign ar_fire_w = s_arvalid & ~rvalid_q;
    assign ar_map_w = ar_off_w <= OFS_MATCH;
    // Flag register alone tells software the cause
    assign rd_val_w = (ar_off_w == OFS_CTRL) ? {26'h0, ctrl_q} :
                      (ar_off_w == OFS_DBG) ? {31'h0, dbg_q} :
                      (ar_off_w == OFS_RATE) ? {16'h0, rate_q} :
                      (ar_off_w == OFS_IEC) | (ar_off_w == OFS_IES) ? 32'(ien_q) :
                      (ar_off_w == OFS_FLAG) ? 32'(flag_q) :
                      (ar_off_w == OFS_STAT) ? {31'h0, busy_q} :
                      (ar_off_w == OFS_MATCH) ? {6'h0, match_q} : 32'h0;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= RESP_OKAY;
        end else if (ar_fire_w) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_val_w;
            rresp_q <= ar_map_w ? RESP_OKAY : RESP_SLVERR;
        end else if (s_rready) begin
            rvalid_q <= 1'b0;
        end
    end
    assign s_rvalid = rvalid_q;
    assign s_rdata = rdata_q;
    assign s_rresp = rresp_q;

    // Engine mode decode
    logic mode_ok_w, usart_w, i2c_w, sync_sel_w, ref_tick_w;
    assign mode_ok_w = eng_ctrl_q.mode <= MODE_I2C_MST;
    assign eng_active = eng_ctrl_q.enable & mode_ok_w;
    assign eng_mode = eng_ctrl_q.mode;
    assign usart_w = (eng_ctrl_q.mode == MODE_USART_EXT) | (eng_ctrl_q.mode == MODE_USART_INT);
    assign i2c_w = (eng_ctrl_q.mode == MODE_I2C_SLV) | (eng_ctrl_q.mode == MODE_I2C_MST);
    // SPI and I2C always clock synchronously
    assign sync_sel_w = usart_w ? eng_ctrl_q.sync_comm : 1'b1;
    assign dbg_halt_en = dbg_q;

    // External clock pin, two stages before the edge detector
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            ext_s3_q <= 1'b0;
        end else begin
            ext_s1_q <= ext_clk_pin;
            ext_s2_q <= ext_s1_q;
            ext_s3_q <= ext_s2_q;
        end
    end
    // External pin limited to half the core rate by sampling
    assign ref_tick_w = (eng_ctrl_q.mode == MODE_USART_EXT) ? (ext_s2_q & ~ext_s3_q) : 1'b1;

    sec_rate_cfg_s rate_cfg_w;
    assign rate_cfg_w = '{run: eng_active, sync_mode: sync_sel_w, divisor: eng_rate_q};

    sec_rate_gen u_rate (
        .aclk(aclk),
        .aresetn(aresetn),
        .cfg(rate_cfg_w),
        .ref_tick(ref_tick_w),
        .tx_tick(tx_tick),
        .rx_tick(rx_tick)
    );

    // Address match
    logic [7:0] am_w, aa_w, ai_w;
    logic masked_w, dual_w, range_w, hit_w;
    assign am_w = i2c_w ? {1'b0, match_addr[6:0]} : match_addr;
    assign aa_w = i2c_w ? {1'b0, match_q.addr[6:0]} : match_q.addr;
    assign ai_w = i2c_w ? {1'b0, match_q.ignore[6:0]} : match_q.ignore;
    assign masked_w = ((am_w ^ aa_w) & ~ai_w) == 8'h00;
    assign dual_w = (am_w == aa_w) | (am_w == ai_w);
    assign range_w = (am_w >= ai_w) & (am_w <= aa_w);
    assign hit_w = (match_q.kind == MATCH_MASKED) ? masked_w :
                   (match_q.kind == MATCH_DUAL) ? dual_w :
                   (match_q.kind == MATCH_RANGE) ? range_w : 1'b0;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hit_q <= 1'b0;
        end else begin
            hit_q <= match_valid & eng_active & hit_w;
        end
    end
    assign match_hit = hit_q;

    // One level, decoded from the flag and enable registers without a clock, so it can wake the system
    assign irq = |(flag_q & ien_q);

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    property p_sync_seq;
        sync_wr_w |=> busy_q [*3] ##1 (!busy_q && flag_q[FLAG_SYNC_RDY]);
    endproperty
    a_sync_seq: assert property (p_sync_seq) else $error("busy sequence wrong");

    property p_stall;
        (busy_q && s_awvalid && s_wvalid && aw_sync_w) |-> (!s_awready && !s_wready);
    endproperty
    a_stall: assert property (p_stall) else $error("sync write not stalled");

    property p_ien_set;
        (wr_fire_w && aw_ies_w && s_wstrb[0] && s_wdata[0]) |=> ien_q[0];
    endproperty
    a_ien_set: assert property (p_ien_set) else $error("unmask set failed");

    property p_ien_clr;
        (wr_fire_w && aw_iec_w && s_wstrb[0] && s_wdata[0]) |=> !ien_q[0];
    endproperty
    a_ien_clr: assert property (p_ien_clr) else $error("unmask clear failed");

    property p_irq_rise;
        (ien_q[FLAG_SYNC_RDY] && sync_done_w && !wr_fire_w) |=> irq;
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("request not raised");

    property p_irq_hold;
        (irq && !wr_fire_w) |=> irq;
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("request dropped");

    property p_srst;
        srst_req_w |=> (!ctrl_q.enable && rate_q == RATE_RST && ien_q == '0);
    endproperty
    a_srst: assert property (p_srst) else $error("soft reset incomplete");

    property p_reserved;
        (eng_ctrl_q.mode > MODE_I2C_MST) |-> !eng_active ##1 (!tx_tick && !rx_tick);
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved mode active");

    property p_all_ignore;
        (match_valid && eng_active && match_q.kind == MATCH_MASKED
         && match_q.ignore == 8'hff) |=> match_hit;
    endproperty
    a_all_ignore: assert property (p_all_ignore) else $error("all-ignore miss");
endmodule : sec_core
`default_nettype wire

// file: hw/sec_pkg.sv
// Shared constants and types of the serial engine common core
package sec_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_DBG = 8'h04;
    localparam logic [7:0] OFS_RATE = 8'h08;
    localparam logic [7:0] OFS_IEC = 8'h0c;
    localparam logic [7:0] OFS_IES = 8'h10;
    localparam logic [7:0] OFS_FLAG = 8'h14;
    localparam logic [7:0] OFS_STAT = 8'h18;
    localparam logic [7:0] OFS_MATCH = 8'h1c;
    // Control field positions
    localparam int CTRL_SRST_BIT = 0;
    localparam int CTRL_EN_BIT = 1;
    localparam int CTRL_MODE_LSB = 2;
    localparam int CTRL_SYNC_BIT = 5;
    localparam int CTRL_W = 6;
    // Flag positions
    localparam int FLAG_SYNC_RDY = 0;
    localparam int FLAG_MATCH = 1;
    localparam int FLAG_ENG_LSB = 2;
    localparam int ENG_EV_N = 6;
    localparam int STAT_BUSY_BIT = 0;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Rate generator constants
    localparam int RATE_W = 16;
    localparam logic [16:0] FRAC_ONE = 17'h10000;
    localparam logic [3:0] ASYNC_TX_DIV_LAST = 4'hf;
    // Crossing latency
    localparam int CLK_PERIOD_NS = 100;
    localparam int SYNC_TIME_NS = 300;
    localparam int SYNC_CYCLES = (SYNC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] SYNC_CNT_INIT = 3'(SYNC_CYCLES);

    typedef enum logic [2:0] {
        MODE_USART_EXT = 3'h0,
        MODE_USART_INT = 3'h1,
        MODE_SPI_SLV = 3'h2,
        MODE_SPI_MST = 3'h3,
        MODE_I2C_SLV = 3'h4,
        MODE_I2C_MST = 3'h5
    } sec_mode_e;

    typedef enum logic [1:0] {
        MATCH_MASKED = 2'h0,
        MATCH_DUAL = 2'h1,
        MATCH_RANGE = 2'h2
    } sec_match_e;

    typedef struct packed {
        logic sync_comm;
        logic [2:0] mode;
        logic enable;
        logic soft_reset_bit;
    } sec_ctrl_s;

    typedef struct packed {
        logic [1:0] kind;
        logic [7:0] ignore;
        logic [7:0] rsv_lo;
        logic [7:0] addr;
    } sec_match_s;

    typedef struct packed {
        logic run;
        logic sync_mode;
        logic [RATE_W-1:0] divisor;
    } sec_rate_cfg_s;

    // Reset values
    localparam sec_ctrl_s CTRL_RST = '0;
    localparam sec_ctrl_s CTRL_SRST_VAL = 6'h01;
    localparam logic [RATE_W-1:0] RATE_RST = 16'h0000;
    localparam sec_match_s MATCH_RST = '0;
endpackage : sec_pkg

// file: hw/sec_rate_gen.sv
// Rate generator: fractional async divider and integer sync divider
`timescale 1ns/1ps
`default_nettype none
module sec_rate_gen
    import sec_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Configuration and reference
    input wire sec_rate_cfg_s cfg,
    input wire logic ref_tick,
    // Rate outputs
    output logic tx_tick,
    output logic rx_tick
);
    logic [15:0] acc_q;
    logic [3:0] div16_q;
    logic [7:0] scnt_q;
    logic phase_q;
    logic [16:0] sum_w;
    logic abase_w;
    logic sbase_w;
    logic shalf_w;

    // Adds 1 - divisor/65536 per reference cycle; carries are the /1 rate
    assign sum_w = {1'b0, acc_q} + (FRAC_ONE - {1'b0, cfg.divisor});
    assign abase_w = ref_tick & sum_w[16];
    // Only the low byte counts in synchronous operation
    assign sbase_w = ref_tick & (scnt_q == cfg.divisor[7:0]);
    assign shalf_w = sbase_w & phase_q;

    always_ff @(posedge aclk) begin
        if (!aresetn || !cfg.run) begin
            acc_q <= 16'h0000;
            div16_q <= 4'h0;
            scnt_q <= 8'h00;
            phase_q <= 1'b0;
            tx_tick <= 1'b0;
            rx_tick <= 1'b0;
        end else if (cfg.sync_mode) begin
            if (ref_tick) begin
                scnt_q <= sbase_w ? 8'h00 : scnt_q + 8'h01;
            end
            if (sbase_w) begin
                phase_q <= ~phase_q;
            end
            tx_tick <= shalf_w;
            rx_tick <= shalf_w;
        end else begin
            if (ref_tick) begin
                acc_q <= sum_w[15:0];
            end
            if (abase_w) begin
                div16_q <= div16_q + 4'h1;
            end
            tx_tick <= abase_w & (div16_q == ASYNC_TX_DIV_LAST);
            rx_tick <= abase_w;
        end
    end
endmodule : sec_rate_gen
`default_nettype wire

// file: sim/sec_core_test.sv
// Self-checking bench for the serial engine common core
`timescale 1ns/1ps
`default_nettype none
module sec_core_test
    import sec_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
    logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00, probe_val = 8'h00;
    logic [31:0] s_wdata = 32'h0;
    logic [3:0] s_wstrb = 4'h0;
    logic [ENG_EV_N-1:0] ev_cmd = '0;
    logic probe_cmd = 1'b0, ext_run = 1'b0;
    wire logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, ext_clk_pin, match_valid;
    wire logic match_hit, eng_active, dbg_halt_en, tx_tick, rx_tick, irq;
    wire logic [1:0] s_bresp, s_rresp;
    wire logic [31:0] s_rdata;
    wire logic [ENG_EV_N-1:0] eng_events;
    wire logic [7:0] match_addr;
    wire logic [2:0] eng_mode;
    int failures = 0;
    int checks = 0;
    logic was_stalled;
    logic seen;
    logic [31:0] rdv;
    logic [1:0] rsp;
    // Match table: kind, ignore, addr, probe, hit
    localparam logic [31:0] MTAB [14] = '{32'h0005a5a1, 32'h0005a5b0, 32'h00f505f1, 32'h00f506f0,
        32'h0ff00a51, 32'h13412341, 32'h13412121, 32'h13412350, 32'h22040201, 32'h22040401,
        32'h22040410, 32'h220401f0, 32'h22040301, 32'h30000000};

    always #50 aclk = ~aclk;

    sec_core dut (.aclk(aclk), .aresetn(aresetn), .s_awvalid(s_awvalid), .s_awready(s_awready),
        .s_awaddr(s_awaddr), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_wdata(s_wdata),
        .s_wstrb(s_wstrb), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_bresp(s_bresp),
        .s_arvalid(s_arvalid), .s_arready(s_arready), .s_araddr(s_araddr), .s_rvalid(s_rvalid),
        .s_rready(s_rready), .s_rdata(s_rdata), .s_rresp(s_rresp), .ext_clk_pin(ext_clk_pin),
        .eng_events(eng_events), .match_valid(match_valid), .match_addr(match_addr),
        .match_hit(match_hit), .eng_active(eng_active), .eng_mode(eng_mode),
        .dbg_halt_en(dbg_halt_en), .tx_tick(tx_tick), .rx_tick(rx_tick), .irq(irq));

    sec_peer_model peer (.aclk(aclk), .aresetn(aresetn), .ev_cmd(ev_cmd), .probe_cmd(probe_cmd),
        .probe_val(probe_val), .ext_run(ext_run), .ext_clk_pin(ext_clk_pin),
        .eng_events(eng_events), .match_valid(match_valid), .match_addr(match_addr));

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic give_verdict;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : give_verdict

    function automatic logic [31:0] ctl(input logic [2:0] m, input logic en, input logic sy);
        return {26'h0, sy, m, en, 1'b0};
    endfunction : ctl

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_go, w_go, bv;
        int n;
        aw_go = 1'b1;
        w_go = 1'b1;
        n = 0;
        @(posedge aclk);
        s_awaddr <= a;
        s_wdata <= d;
        s_wstrb <= 4'hf;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        do begin
            @(negedge aclk);
            aw_go = aw_go && !s_awready;
            w_go = w_go && !s_wready;
            n++;
            @(posedge aclk);
            s_awvalid <= aw_go;
            s_wvalid <= w_go;
        end while (aw_go || w_go);
        was_stalled = (n > 1);
        do begin
            @(negedge aclk);
            bv = s_bvalid;
            rsp = s_bresp;
            @(posedge aclk);
        end while (!bv);
        s_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        logic hit;
        @(posedge aclk);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        do begin
            @(negedge aclk);
            hit = s_arready;
            @(posedge aclk);
        end while (!hit);
        s_arvalid <= 1'b0;
        do begin
            @(negedge aclk);
            hit = s_rvalid;
            rdv = s_rdata;
            rsp = s_rresp;
            @(posedge aclk);
        end while (!hit);
        s_rready <= 1'b0;
    endtask : rd

    // Six cycles outlast the crossing
    task automatic cfg(input logic [31:0] c);
        wr(OFS_CTRL, c);
        repeat (6) @(posedge aclk);
    endtask : cfg

    task automatic count_ticks(input int n, output int tx, output int rx);
        tx = 0;
        rx = 0;
        repeat (n) begin
            @(negedge aclk);
            if (tx_tick === 1'b1) tx++;
            if (rx_tick === 1'b1) rx++;
        end
    endtask : count_ticks

    task automatic run_rate(input logic [31:0] c, input logic [15:0] dv, input int etx, erx);
        int tx, rx;
        cfg(32'h0);
        wr(OFS_RATE, {16'h0, dv});
        cfg(c);
        repeat (40) @(posedge aclk);
        count_ticks(160, tx, rx);
        check("tx ticks", 32'(etx), 32'(tx));
        check("rx ticks", 32'(erx), 32'(rx));
    endtask : run_rate

    task automatic probe(input logic [7:0] v);
        @(posedge aclk);
        probe_cmd <= 1'b1;
        probe_val <= v;
        @(posedge aclk);
        probe_cmd <= 1'b0;
        seen = 1'b0;
        repeat (4) begin
            @(negedge aclk);
            seen |= (match_hit === 1'b1);
        end
    endtask : probe

    task automatic chk_irq(input logic e);
        repeat (2) @(negedge aclk);
        check("irq", {31'h0, e}, {31'h0, irq});
    endtask : chk_irq

    task automatic t_basic;
        int tx, rx;
        rd(OFS_CTRL);
        check("ctrl after reset", 32'h0, rdv);
        rd(8'h20);
        check("unmapped read", {30'h0, RESP_SLVERR}, {30'h0, rsp});
        wr(8'h24, 32'h1);
        check("unmapped write", {30'h0, RESP_SLVERR}, {30'h0, rsp});
        for (int m = 0; m < 8; m++) begin
            wr(OFS_CTRL, ctl(3'(m), 1'b1, 1'b0));
            rd(OFS_STAT);
            check("busy at once", 32'h1, rdv);
            repeat (6) @(posedge aclk);
            check("engine active", {31'h0, m < 6}, {31'h0, eng_active});
            check("engine mode", 32'(m), {29'h0, eng_mode});
            rd(OFS_FLAG);
            check("crossing done flag", 32'h1, rdv & 32'h1);
            wr(OFS_FLAG, 32'h1);
        end
        cfg(ctl(3'h1, 1'b0, 1'b0));
        count_ticks(32, tx, rx);
        check("disabled", 32'h0, {31'h0, eng_active} | 32'(tx + rx));
        wr(OFS_CTRL, ctl(3'h1, 1'b0, 1'b0));
        wr(OFS_RATE, 32'h0000beef);
        check("rate write stalled", 32'h1, {31'h0, was_stalled});
        repeat (6) @(posedge aclk);
        rd(OFS_RATE);
        check("stalled write landed", 32'h0000beef, rdv);
        $display("test modes and crossing done");
    endtask : t_basic

    task automatic t_rate;
        run_rate(ctl(3'h1, 1'b1, 1'b0), 16'h0000, 10, 160);
        run_rate(ctl(3'h1, 1'b1, 1'b0), 16'h8000, 5, 80);
        run_rate(ctl(3'h1, 1'b1, 1'b1), 16'h0003, 20, 20);
        run_rate(ctl(3'h3, 1'b1, 1'b0), 16'h0103, 20, 20);
        @(posedge aclk);
        ext_run <= 1'b1;
        run_rate(ctl(3'h0, 1'b1, 1'b0), 16'h0000, 5, 80);
        ext_run <= 1'b0;
        $display("test rate generator done");
    endtask : t_rate

    task automatic t_match;
        logic [31:0] e;
        cfg(ctl(3'h3, 1'b1, 1'b0));
        foreach (MTAB[i]) begin
            e = MTAB[i];
            wr(OFS_MATCH, {6'h0, e[29:28], e[27:20], 8'h0, e[19:12]});
            probe(e[11:4]);
            check("match hit", {31'h0, e[0]}, {31'h0, seen});
        end
        rd(OFS_FLAG);
        check("match flag", 32'h2, rdv & 32'h2);
        wr(OFS_MATCH, 32'h00000012);
        probe(8'h92);
        check("eight bit compare", 32'h0, {31'h0, seen});
        cfg(ctl(3'h4, 1'b1, 1'b0));
        probe(8'h92);
        check("seven bit compare", 32'h1, {31'h0, seen});
        $display("test address match done");
    endtask : t_match

    task automatic t_irq;
        cfg(ctl(3'h1, 1'b1, 1'b0));
        wr(OFS_FLAG, 32'hffffffff);
        wr(OFS_IES, 32'h4);
        chk_irq(1'b0);
        @(posedge aclk);
        ev_cmd <= 6'h03;
        @(posedge aclk);
        ev_cmd <= 6'h00;
        chk_irq(1'b1);
        rd(OFS_FLAG);
        check("flags name the cause", 32'h0000000c, rdv);
        wr(OFS_IEC, 32'h4);
        chk_irq(1'b0);
        rd(OFS_IES);
        check("enables after clear", 32'h0, rdv);
        wr(OFS_IES, 32'h8);
        chk_irq(1'b1);
        wr(OFS_FLAG, 32'h8);
        chk_irq(1'b0);
        wr(OFS_IES, 32'h1);
        cfg(ctl(3'h3, 1'b1, 1'b0));
        chk_irq(1'b1);
        wr(OFS_FLAG, 32'h1);
        chk_irq(1'b0);
        $display("test interrupts done");
    endtask : t_irq

    task automatic t_srst;
        wr(OFS_DBG, 32'h1);
        wr(OFS_IES, 32'h3);
        wr(OFS_RATE, 32'h1234);
        cfg(ctl(3'h1, 1'b1, 1'b0));
        cfg(32'h1);
        rd(OFS_CTRL);
        check("ctrl after soft reset", 32'h0, rdv);
        rd(OFS_RATE);
        check("rate after soft reset", 32'h0, rdv);
        rd(OFS_IES);
        check("enables after soft reset", 32'h0, rdv);
        rd(OFS_DBG);
        check("debug kept", 32'h1, rdv);
        check("disabled by soft reset", 32'h0, {31'h0, eng_active});
        check("debug output kept", 32'h1, {31'h0, dbg_halt_en});
        $display("test soft reset done");
    endtask : t_srst

    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        t_basic();
        t_rate();
        t_match();
        t_irq();
        t_srst();
        give_verdict();
    end

    // Whole run needs some 1600 cycles
    initial begin
        #3000000;
        failures++;
        $display("watchdog expired");
        give_verdict();
    end
endmodule : sec_core_test
`default_nettype wire

// file: sim/sec_peer_model.sv
// Engine-side peer model: event sources, address probes, external clock
`timescale 1ns/1ps
`default_nettype none
module sec_peer_model
    import sec_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bench commands
    input wire logic [ENG_EV_N-1:0] ev_cmd,
    input wire logic probe_cmd,
    input wire logic [7:0] probe_val,
    input wire logic ext_run,
    // Toward the core
    output logic ext_clk_pin = 1'b0,
    output logic [ENG_EV_N-1:0] eng_events = '0,
    output logic match_valid = 1'b0,
    output logic [7:0] match_addr = 8'h00
);
    always @(posedge aclk) begin
        if (!aresetn) begin
            ext_clk_pin <= 1'b0;
            eng_events <= '0;
            match_valid <= 1'b0;
            match_addr <= 8'h00;
        end else begin
            // External clock stands still unless a run is asked for
            if (ext_run) begin
                ext_clk_pin <= ~ext_clk_pin;
            end
            eng_events <= ev_cmd;
            match_valid <= probe_cmd;
            // Address lines are not held between probes
            match_addr <= probe_cmd ? probe_val : ~match_addr;
        end
    end
endmodule : sec_peer_model
`default_nettype wire
